// *** src/sram_port_pkg.sv ***
package sram_port_pkg;

    // Array shape of the 1M x 36 variant
    localparam int ADDR_W_DEF     = 20;
    localparam int DATA_W_DEF     = 36;
    localparam int LANES_DEF      = 4;

    // Four-beat burst, two low address bits step
    localparam int BURST_CNT_W    = 2;

    // Posted write buffer between the bus and the array
    localparam int FIFO_DEPTH_DEF = 8;

    // Most entries allowed in the write buffer when a new operation is taken
    localparam int FWD_LEVEL_MAX  = 1;

    // Reset values
    localparam logic [BURST_CNT_W-1:0] BURST_CNT_RST = 2'h0;
    localparam logic                   DRIVE_RST     = 1'h0;
    localparam logic                   POWER_RST     = 1'h1;
    localparam logic                   SYNC_RST      = 1'h0;
    localparam logic                   READY_RST     = 1'h1;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } op_t;

endpackage : sram_port_pkg

// *** src/write_buffer_if.sv ***
`timescale 1ns/1ns
interface write_buffer_if #(
    parameter int WIDTH   = 8,
    parameter int LEVEL_W = 4
);
    logic               in_valid;
    logic               in_ready;
    logic [WIDTH-1:0]   in_data;
    logic               out_valid;
    logic               out_ready;
    logic [WIDTH-1:0]   out_data;
    logic [LEVEL_W-1:0] level;

    modport source (
        output in_valid,
        input  in_ready,
        output in_data,
        input  out_valid,
        output out_ready,
        input  out_data,
        input  level
    );

    modport buffer (
        input  in_valid,
        output in_ready,
        input  in_data,
        output out_valid,
        input  out_ready,
        output out_data,
        output level
    );
endinterface : write_buffer_if

// *** src/write_buffer_fifo.sv ***
`timescale 1ns/1ns
module write_buffer_fifo #(
    parameter int WIDTH   = 8,
    parameter int DEPTH   = 8,
    parameter int LEVEL_W = 4
)(
    input wire logic    clk,
    input wire logic    reset_n,
    write_buffer_if.buffer port_b
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << LEVEL_W) <= DEPTH) begin : g_bad_shape
        $error("write_buffer_fifo: DEPTH below 2 or LEVEL_W too narrow");
    end

    logic [WIDTH-1:0]   store_r [DEPTH];
    logic [PTR_W-1:0]   wr_ptr_r;
    logic [PTR_W-1:0]   rd_ptr_r;
    logic [LEVEL_W-1:0] count_r;

    wire push = port_b.in_valid & port_b.in_ready;
    wire pop  = port_b.out_valid & port_b.out_ready;

    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        // Explicit wrap so a depth that is not a power of two still works
        bump = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
    endfunction : bump

    assign port_b.in_ready  = (count_r != LEVEL_W'(DEPTH));
    assign port_b.out_valid = (count_r != '0);
    assign port_b.out_data  = store_r[rd_ptr_r];
    assign port_b.level     = count_r;

    always_ff @(posedge clk) begin
        if (push) begin
            store_r[wr_ptr_r] <= port_b.in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= bump(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= bump(rd_ptr_r);
            end
            if (push && !pop) begin
                count_r <= LEVEL_W'(count_r + 1'b1);
            end else if (pop && !push) begin
                count_r <= LEVEL_W'(count_r - 1'b1);
            end
        end
    end

endmodule : write_buffer_fifo

// *** src/flow_through_burst_sram_port.sv ***
`timescale 1ns/1ns
// Contract
// - Array is 1M x 36, 2M x 18 or 512K x 72
// - Synchronous inputs captured on rising clock edge
// - Qualifier high: edge ignored, all state held; power, ready and refused flags still update and the write buffer keeps draining into the array
// - Write strobe plus byte selects; only selected lanes
// - Self-timed internal write, no external pulse
// - New operation only with all three selects active
// - Output enable tri-states drivers asynchronously
// - Drivers off during every write data phase
// - Internal timing controls drivers without output enable
// - Any read/write mix back to back, no idle
// - Burst order linear or interleaved by strap
// - Low power on sleep request or deselect
// - Boundary-scan test port per standard architecture; not modelled in this port
module flow_through_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int ADDR_W     = ADDR_W_DEF,
    parameter int DATA_W     = DATA_W_DEF,
    parameter int LANES      = LANES_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              burst_advance,
    input  wire logic              write_enable_n,
    input  wire logic [LANES-1:0]  byte_lane_write_sel_n,
    input  wire logic              chip_select_a_n,
    input  wire logic              chip_select_b,
    input  wire logic              chip_select_c_n,
    input  wire logic              clk_qualifier_n,
    input  wire logic              output_enable_n,
    input  wire logic              burst_order_strap,
    input  wire logic              sleep_request,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    output logic                   power_down,
    output logic                   write_buffer_ready,
    output logic                   read_active,
    output logic                   write_data_phase,
    output logic      [BURST_CNT_W-1:0] burst_position,
    output logic                   op_refused
);

    localparam int LANE_W  = DATA_W / LANES;
    localparam int ENTRY_W = ADDR_W + LANES + DATA_W;
    localparam int LEVEL_W = $clog2(FIFO_DEPTH + 1);
    localparam int WORDS   = 1 << ADDR_W;

    // The three documented shapes; other widths are refused
    if (!((DATA_W == 36 && LANES == 4) || (DATA_W == 18 && LANES == 2) ||
          (DATA_W == 72 && LANES == 8))) begin : g_bad_width
        $error("flow_through_burst_sram_port: unsupported data width or lanes");
    end
    if (ADDR_W <= BURST_CNT_W || FIFO_DEPTH <= FWD_LEVEL_MAX + 1) begin : g_bad_size
        $error("flow_through_burst_sram_port: address or buffer too small");
    end

    // Array, flip-flop storage addressed by word index
    logic [DATA_W-1:0] mem [WORDS];

    // Controller-side state, all but the power, ready and refused flags frozen by the qualifier
    op_t                    op_r;
    op_t                    op_nxt;
    logic [ADDR_W-1:0]      start_r;
    logic [ADDR_W-1:0]      start_nxt;
    logic [BURST_CNT_W-1:0] cnt_r;
    logic [BURST_CNT_W-1:0] cnt_nxt;
    logic [ADDR_W-1:0]      cur_addr_r;
    logic [ADDR_W-1:0]      cur_addr_nxt;
    logic [LANES-1:0]       mask_r;
    logic [LANES-1:0]       mask_nxt;
    logic [DATA_W-1:0]      dq_out_r;
    logic [DATA_W-1:0]      dq_out_nxt;
    logic                   drive_r;
    logic                   drive_nxt;
    logic                   power_r;
    logic                   ready_r;
    logic                   refused_r;
    logic                   refused_nxt;
    logic                   wphase_r;

    // Asynchronous pins, two flops before use
    logic sleep_meta_r;
    logic sleep_sync_r;
    logic strap_meta_r;
    logic strap_sync_r;

    write_buffer_if #(.WIDTH(ENTRY_W), .LEVEL_W(LEVEL_W)) wbuf ();

    write_buffer_fifo #(
        .WIDTH   (ENTRY_W),
        .DEPTH   (FIFO_DEPTH),
        .LEVEL_W (LEVEL_W)
    ) u_write_buffer (
        .clk     (clk),
        .reset_n (reset_n),
        .port_b  (wbuf.buffer)
    );

    // Next word of a four-beat burst; only the two low bits move
    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0]      start,
        input logic [BURST_CNT_W-1:0] cnt,
        input logic                   interleave
    );
        logic [BURST_CNT_W-1:0] low;
        low = interleave ? (start[BURST_CNT_W-1:0] ^ cnt)
                         : BURST_CNT_W'(start[BURST_CNT_W-1:0] + cnt);
        burst_addr = {start[ADDR_W-1:BURST_CNT_W], low};
    endfunction : burst_addr

    // Byte-lane merge, used by the array write and by read forwarding
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [LANES-1:0]  lanes
    );
        lane_merge = old_word;
        for (int i = 0; i < LANES; i++) begin
            if (lanes[i]) begin
                lane_merge[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
    endfunction : lane_merge

    // Decode of the sampled pins
    wire edge_taken   = ~clk_qualifier_n;
    wire all_selected = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;
    wire interleave   = strap_sync_r;
    // After sleep a backlog may sit in the buffer; forwarding sees only the head
    wire buf_shallow  = (wbuf.level <= LEVEL_W'(FWD_LEVEL_MAX));
    wire can_accept   = ~sleep_sync_r & buf_shallow & wbuf.in_ready;

    // Write data arrives one taken edge after its address
    wire push_write   = edge_taken & (op_r == OP_WRITE);
    wire [ENTRY_W-1:0] push_entry = {cur_addr_r, mask_r, dq_in};

    // Head of the write buffer, drained into the array
    wire [ADDR_W-1:0] head_addr = wbuf.out_data[ENTRY_W-1 -: ADDR_W];
    wire [LANES-1:0]  head_mask = wbuf.out_data[DATA_W +: LANES];
    wire [DATA_W-1:0] head_data = wbuf.out_data[DATA_W-1:0];
    // Array is quiet in sleep; the buffer keeps posted writes meanwhile
    wire drain = wbuf.out_valid & ~sleep_sync_r;

    assign wbuf.in_valid  = push_write;
    assign wbuf.in_data   = push_entry;
    assign wbuf.out_ready = ~sleep_sync_r;

    // Read forwarding: array, then head entry, then the write landing now
    wire head_hit = wbuf.out_valid & (head_addr == cur_addr_nxt);
    wire push_hit = push_write & (cur_addr_r == cur_addr_nxt);
    wire [DATA_W-1:0] rd_array = mem[cur_addr_nxt];
    wire [DATA_W-1:0] rd_head  = head_hit ? lane_merge(rd_array, head_data, head_mask)
                                          : rd_array;
    wire [DATA_W-1:0] rd_word  = push_hit ? lane_merge(rd_head, dq_in, mask_r)
                                          : rd_head;

    // Operation sequencing
    always_comb begin
        op_nxt      = op_r;
        start_nxt   = start_r;
        cnt_nxt     = cnt_r;
        mask_nxt    = mask_r;
        refused_nxt = 1'b0;
        if (edge_taken) begin
            if (!burst_advance) begin
                if (all_selected && can_accept) begin
                    op_nxt    = write_enable_n ? OP_READ : OP_WRITE;
                    start_nxt = addr;
                    cnt_nxt   = BURST_CNT_RST;
                    mask_nxt  = ~byte_lane_write_sel_n;
                end else begin
                    op_nxt      = OP_IDLE;
                    refused_nxt = all_selected;
                end
            end else if (op_r != OP_IDLE && can_accept) begin
                cnt_nxt  = BURST_CNT_W'(cnt_r + 1'b1);
                mask_nxt = ~byte_lane_write_sel_n;
            end else begin
                op_nxt      = OP_IDLE;
                refused_nxt = (op_r != OP_IDLE);
            end
        end
    end

    assign cur_addr_nxt = burst_addr(start_nxt, cnt_nxt, interleave);

    // Output data and driver control
    always_comb begin
        dq_out_nxt = dq_out_r;
        drive_nxt  = drive_r;
        if (edge_taken) begin
            drive_nxt = (op_nxt == OP_READ);
            if (op_nxt == OP_READ) begin
                dq_out_nxt = rd_word;
            end
        end
    end

    // Array write port
    always_ff @(posedge clk) begin
        if (drain) begin
            mem[head_addr] <= lane_merge(mem[head_addr], head_data, head_mask);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_meta_r <= SYNC_RST;
            sleep_sync_r <= SYNC_RST;
            strap_meta_r <= SYNC_RST;
            strap_sync_r <= SYNC_RST;
        end else begin
            sleep_meta_r <= sleep_request;
            sleep_sync_r <= sleep_meta_r;
            strap_meta_r <= burst_order_strap;
            strap_sync_r <= strap_meta_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op_r       <= OP_IDLE;
            start_r    <= '0;
            cnt_r      <= BURST_CNT_RST;
            cur_addr_r <= '0;
            mask_r     <= '0;
        end else begin
            op_r       <= op_nxt;
            start_r    <= start_nxt;
            cnt_r      <= cnt_nxt;
            cur_addr_r <= cur_addr_nxt;
            mask_r     <= mask_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_out_r  <= '0;
            drive_r   <= DRIVE_RST;
            power_r   <= POWER_RST;
            ready_r   <= READY_RST;
            refused_r <= 1'b0;
            wphase_r  <= 1'b0;
        end else begin
            dq_out_r  <= dq_out_nxt;
            drive_r   <= drive_nxt;
            power_r   <= sleep_sync_r | (op_nxt == OP_IDLE);
            ready_r   <= wbuf.in_ready & buf_shallow;
            refused_r <= refused_nxt;
            wphase_r  <= (op_nxt == OP_WRITE);
        end
    end

    // Driver enable must fall at once with output enable, so it is not registered
    assign dq_oe              = drive_r & ~output_enable_n;
    assign dq_out             = dq_out_r;
    assign power_down         = power_r;
    assign write_buffer_ready = ready_r;
    assign read_active        = drive_r;
    assign write_data_phase   = wphase_r;
    assign burst_position     = cnt_r;
    assign op_refused         = refused_r;

    // Boundary scan sits outside this port and is not modelled here

endmodule : flow_through_burst_sram_port

// *** test/flow_through_burst_sram_port_props.sv ***
`timescale 1ns/1ns
module flow_through_burst_sram_port_props
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int LANES  = LANES_DEF
)(
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic [ADDR_W-1:0]      addr,
    input wire logic                   burst_advance,
    input wire logic                   write_enable_n,
    input wire logic [LANES-1:0]       byte_lane_write_sel_n,
    input wire logic                   chip_select_a_n,
    input wire logic                   chip_select_b,
    input wire logic                   chip_select_c_n,
    input wire logic                   clk_qualifier_n,
    input wire logic                   output_enable_n,
    input wire logic                   burst_order_strap,
    input wire logic                   sleep_request,
    input wire logic [DATA_W-1:0]      dq_in,
    input wire logic [DATA_W-1:0]      dq_out,
    input wire logic                   dq_oe,
    input wire logic                   power_down,
    input wire logic                   write_buffer_ready,
    input wire logic                   read_active,
    input wire logic                   write_data_phase,
    input wire logic [BURST_CNT_W-1:0] burst_position,
    input wire logic                   op_refused
);
    wire logic sel_ok = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_load;
        !clk_qualifier_n && !burst_advance;
    endsequence
    // Qualifier low too, since a held edge also freezes read_active while the sleep sync runs on
    sequence s_sleep_held;
        (sleep_request && !clk_qualifier_n) [*5];
    endsequence
    a_oe_gate: assert property (output_enable_n |-> !dq_oe)
        else $error("drivers on with output enable inactive");
    a_write_hiz: assert property (write_data_phase |-> !dq_oe)
        else $error("drivers on in write data phase");
    a_qual_hold: assert property (clk_qualifier_n |=> $stable(dq_out) &&
        $stable(burst_position) && $stable(read_active) && $stable(write_data_phase))
        else $error("state moved on an ignored edge");
    a_read_cause: assert property (s_load ##1 read_active |-> $past(write_enable_n && sel_ok))
        else $error("read started without read load");
    a_write_cause: assert property (s_load ##1 write_data_phase |->
        $past(!write_enable_n && sel_ok)) else $error("write started without write load");
    a_burst_step: assert property (!clk_qualifier_n && burst_advance ##1
        (read_active || write_data_phase) |-> burst_position == $past(burst_position) + 2'h1)
        else $error("burst beat did not step");
    a_deselect_idle: assert property (!clk_qualifier_n && !burst_advance && !sel_ok |=>
        power_down && !read_active && !write_data_phase) else $error("deselect not idle");
    a_sleep_power: assert property (s_sleep_held |=> power_down && !read_active)
        else $error("active while sleeping");
endmodule : flow_through_burst_sram_port_props
bind flow_through_burst_sram_port flow_through_burst_sram_port_props #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)
) i_props (.clk, .reset_n, .addr, .burst_advance, .write_enable_n, .byte_lane_write_sel_n,
    .chip_select_a_n, .chip_select_b, .chip_select_c_n, .clk_qualifier_n, .output_enable_n,
    .burst_order_strap, .sleep_request, .dq_in, .dq_out, .dq_oe, .power_down,
    .write_buffer_ready, .read_active, .write_data_phase, .burst_position, .op_refused);

// *** test/bus_master_model.sv ***
`timescale 1ns/1ns
module bus_master_model
    import sram_port_pkg::*;
#(
    parameter int AW = ADDR_W_DEF,
    parameter int DW = DATA_W_DEF,
    parameter int LW = LANES_DEF
)(
    input wire logic     clk,
    output logic [AW-1:0] addr,
    output logic          burst_advance,
    output logic          write_enable_n,
    output logic [LW-1:0] byte_lane_write_sel_n,
    output logic          chip_select_a_n,
    output logic          chip_select_b,
    output logic          chip_select_c_n,
    output logic          clk_qualifier_n,
    output logic [DW-1:0] dq_in
);
    logic          cur_wr;
    logic          pend;
    logic [DW-1:0] pend_d;
    initial begin
        {cur_wr, pend, pend_d, dq_in, addr, burst_advance, clk_qualifier_n} = '0;
        {write_enable_n, byte_lane_write_sel_n} = '1;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h5;
    end
    // A released bus shows the inverse, never a stale copy
    task automatic next_data();
        dq_in = pend ? pend_d : ~dq_in;
    endtask : next_data
    task automatic beat(input logic adv, input logic we_n, input logic [AW-1:0] a,
                        input logic [LW-1:0] bw_n, input logic [DW-1:0] wd);
        @(negedge clk);
        next_data();
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h2;
        {burst_advance, write_enable_n, addr, byte_lane_write_sel_n} = {adv, we_n, a, bw_n};
        clk_qualifier_n = 1'b0;
        cur_wr = adv ? cur_wr : !we_n;
        pend = cur_wr;
        pend_d = wd;
    endtask : beat
    // Pending write data stays on the bus until a taken edge
    task automatic stall();
        @(negedge clk);
        clk_qualifier_n = 1'b1;
    endtask : stall
    task automatic idle(input logic [2:0] cs);
        @(negedge clk);
        next_data();
        {chip_select_a_n, chip_select_b, chip_select_c_n} = cs;
        {burst_advance, clk_qualifier_n, cur_wr, pend} = 4'h0;
    endtask : idle
endmodule : bus_master_model

// *** test/flow_through_burst_sram_port_bench.sv ***
`timescale 1ns/1ns
module flow_through_burst_sram_port_bench
    import sram_port_pkg::*;
    ();
    localparam int AW = ADDR_W_DEF;
    localparam int DW = DATA_W_DEF;
    localparam int LW = LANES_DEF;
    localparam int LN = DW / LW;
    logic clk, reset_n, output_enable_n, burst_order_strap, sleep_request, taken_r;
    logic burst_advance, write_enable_n, clk_qualifier_n, op_refused, write_data_phase;
    logic chip_select_a_n, chip_select_b, chip_select_c_n;
    logic dq_oe, power_down, write_buffer_ready, read_active;
    logic [AW-1:0]          addr, s;
    logic [LW-1:0]          byte_lane_write_sel_n;
    logic [DW-1:0]          dq_in, dq_out;
    logic [BURST_CNT_W-1:0] burst_position;
    logic [DW-1:0]          ref_mem [int];
    logic [DW-1:0]          exp_q [$];
    int                     err_count, n_tests;
    bus_master_model i_bus_master_model (.clk, .addr, .burst_advance, .write_enable_n,
        .byte_lane_write_sel_n, .chip_select_a_n, .chip_select_b, .chip_select_c_n,
        .clk_qualifier_n, .dq_in);
    flow_through_burst_sram_port i_flow_through_burst_sram_port (.clk, .reset_n, .addr,
        .burst_advance, .write_enable_n, .byte_lane_write_sel_n, .chip_select_a_n,
        .chip_select_b, .chip_select_c_n, .clk_qualifier_n, .output_enable_n,
        .burst_order_strap, .sleep_request, .dq_in, .dq_out, .dq_oe, .power_down,
        .write_buffer_ready, .read_active, .write_data_phase, .burst_position, .op_refused);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [AW-1:0] baddr(input logic [AW-1:0] a, input logic [1:0] k,
                                            input logic il);
        return {a[AW-1:2], il ? a[1:0] ^ k : a[1:0] + k};
    endfunction : baddr
    task automatic rd(input logic adv, input logic [AW-1:0] a);
        i_bus_master_model.beat(adv, 1'b1, a, '1, '0);
        exp_q.push_back(ref_mem[a]);
    endtask : rd
    task automatic wr(input logic adv, input logic [AW-1:0] a, input logic [LW-1:0] bw_n);
        logic [DW-1:0] d;
        d = DW'({$urandom, $urandom});
        i_bus_master_model.beat(adv, 1'b0, a, bw_n, d);
        for (int i = 0; i < LW; i++)
            if (!bw_n[i]) ref_mem[a][i*LN +: LN] = d[i*LN +: LN];
    endtask : wr
    // Look just after the edge, once what it launched has settled
    always @(posedge clk) begin
        taken_r = !clk_qualifier_n;
        #1;
        if (reset_n && taken_r && read_active === 1'b1) begin
            check(DW'(dq_oe), DW'(!output_enable_n));
            check(dq_out, exp_q.size() ? exp_q.pop_front() : 'x);
        end
    end
    initial begin
        #(8 * 5000);
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hE004));
        {reset_n, output_enable_n, burst_order_strap, sleep_request} = 4'h0;
        {err_count, n_tests} = '0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        check(DW'({power_down, write_buffer_ready, dq_oe, read_active}), DW'(4'hC));
        repeat (3) i_bus_master_model.idle(3'h5);
        for (int i = 0; i < 16; i++) wr(1'b0, AW'(i), '0);
        for (int i = 0; i < 200; i++) begin
            output_enable_n = 1'(($urandom % 4) == 0);
            if ($urandom % 2) rd(1'b0, AW'($urandom % 16));
            else wr(1'b0, AW'($urandom % 16), LW'($urandom));
        end
        output_enable_n = 1'b0;
        for (int il = 0; il < 2; il++) begin
            burst_order_strap = 1'(il);
            repeat (3) i_bus_master_model.idle(3'h5);
            s = AW'(20'h00104 + $urandom % 4);
            for (int k = 0; k < 4; k++) wr(k != 0, baddr(s, 2'(k), 1'(il)), '0);
            for (int k = 0; k < 4; k++) wr(k != 0, baddr(baddr(s, 2'h1, 1'b0), 2'(k), 1'(il)),
                                           LW'($urandom));
            for (int k = 0; k < 5; k++) begin
                if (k == 2) i_bus_master_model.stall();
                rd(k != 0, baddr(baddr(s, 2'h2, 1'b0), 2'(k), 1'(il)));
            end
        end
        for (int j = 0; j < 3; j++) begin
            i_bus_master_model.idle(3'h2 ^ (3'h1 << j));
            @(posedge clk);
            #1 check(DW'({power_down, read_active}), DW'(2'h2));
        end
        @(negedge clk);
        sleep_request = 1'b1;
        repeat (4) i_bus_master_model.idle(3'h5);
        i_bus_master_model.beat(1'b0, 1'b1, AW'(3), '1, '0);
        @(posedge clk);
        #1 check(DW'({op_refused, read_active, power_down}), DW'(3'h5));
        @(negedge clk);
        sleep_request = 1'b0;
        repeat (4) i_bus_master_model.idle(3'h5);
        check(DW'({write_buffer_ready, op_refused}), DW'(2'h2));
        rd(1'b0, AW'(3));
        repeat (2) i_bus_master_model.idle(3'h5);
        check(DW'(exp_q.size()), '0);
        print_verdict();
    end
endmodule : flow_through_burst_sram_port_bench
